// ---- rtl/rsc_defs.svh ----
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define RSC_REG_CTRL 4'h0
`define RSC_REG_ADV 4'h4
`define RSC_REG_STRAP 4'h8
// ****************************************
// field positions
// ****************************************
`define RSC_CTRL_DUP_BIT 8
`define RSC_CTRL_AN_BIT 12
`define RSC_CTRL_SPD_BIT 13
`define RSC_CTRL_LOOP_BIT 14
`define RSC_STAT_RUN_BIT 8
`define RSC_STAT_TXACT_BIT 9
// ****************************************
// reset and strap values
// ****************************************
`define RSC_CTRL_BASE 16'h0100
`define RSC_ADV_HI 16'h01e1
`define RSC_ADV_LO 16'h0061
`define RSC_ADDR_HI 5'h03
`define RSC_ADDR_LO 5'h00
// ****************************************
// timing counts
// ****************************************
`define RSC_SYNC_WAIT 2'h2
`endif

// ---- rtl/rsc_pkg.sv ----
package rsc_pkg;
    typedef enum logic [2:0] {
        RSC_WAIT = 3'b001,
        RSC_CAP = 3'b010,
        RSC_RUN = 3'b100
    } rsc_state_t;

    typedef struct packed {
        rsc_state_t st;
        logic [1:0] wait_cnt;
        logic [1:0] an_sync;
        logic [1:0] ad_sync;
        logic [1:0] tx_sync;
        logic [4:0] mgmt_addr;
        logic [15:0] ctrl;
        logic [15:0] adv;
        logic waitreq;
        logic [31:0] rdata;
        logic led;
        logic led_oe;
    } rsc_core_t;

    typedef struct packed {
        logic [1:0] cap_sync;
        logic [1:0] loop_sync;
        logic crs_dv;
        logic [1:0] rxd;
        logic crs_oe;
        logic txv;
        logic [1:0] txd;
    } rsc_link_t;
endpackage : rsc_pkg

// ---- rtl/rsc_top.sv ----
`timescale 1ns/1ps
`include "rsc_defs.svh"

module rsc_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic rmii_ref_clk,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic mgmt_address_strap,
    output logic crs_dv,
    output logic crs_dv_oe,
    output logic [1:0] rxd,
    input wire logic autoneg_speed_strap,
    output logic led,
    output logic led_oe,
    input wire logic txen,
    input wire logic [1:0] txd,
    input wire logic rx_valid,
    input wire logic [1:0] rx_dibit,
    output logic tx_valid,
    output logic [1:0] tx_dibit,
    output logic [4:0] mgmt_addr,
    output logic an_enable,
    output logic speed_100
);

    // ****************************************
    // core domain
    // ****************************************
    rsc_pkg::rsc_core_t c_q;
    rsc_pkg::rsc_core_t c_d;
    rsc_pkg::rsc_link_t l_q;
    rsc_pkg::rsc_link_t l_d;

    always_comb begin
        logic [31:0] rd;
        rd = 32'h0;
        c_d = c_q;
        // strap pins and the link transmit flag pass two flops before the core reads them
        c_d.an_sync = {c_q.an_sync[0], autoneg_speed_strap};
        c_d.ad_sync = {c_q.ad_sync[0], mgmt_address_strap};
        c_d.tx_sync = {c_q.tx_sync[0], l_q.txv};
        case (avs_address)
            `RSC_REG_CTRL: begin
                rd = {16'h0, c_q.ctrl};
            end
            `RSC_REG_ADV: begin
                rd = {16'h0, c_q.adv};
            end
            `RSC_REG_STRAP: begin
                rd = {27'h0, c_q.mgmt_addr};
                rd[`RSC_STAT_RUN_BIT] = c_q.led_oe;
                rd[`RSC_STAT_TXACT_BIT] = c_q.tx_sync[1];
            end
            default: begin
                rd = 32'h0;
            end
        endcase
        // one wait cycle, then a single answer cycle
        c_d.waitreq = 1'b1;
        if ((avs_read || avs_write) && c_q.waitreq) begin
            c_d.waitreq = 1'b0;
            c_d.rdata = rd;
        end
        if (avs_write && !c_q.waitreq) begin
            case (avs_address)
                `RSC_REG_CTRL: begin
                    c_d.ctrl = avs_writedata[15:0];
                end
                `RSC_REG_ADV: begin
                    c_d.adv = avs_writedata[15:0];
                end
                default: begin
                    c_d.ctrl = c_q.ctrl;
                end
            endcase
        end
        case (c_q.st)
            rsc_pkg::RSC_WAIT: begin
                // synchronisers must settle before the straps are trusted
                c_d.wait_cnt = c_q.wait_cnt + 2'h1;
                if (c_q.wait_cnt == `RSC_SYNC_WAIT) begin
                    c_d.st = rsc_pkg::RSC_CAP;
                end
            end
            rsc_pkg::RSC_CAP: begin
                c_d.mgmt_addr = c_q.ad_sync[1] ? `RSC_ADDR_HI : `RSC_ADDR_LO;
                c_d.ctrl[`RSC_CTRL_AN_BIT] = c_q.an_sync[1];
                c_d.ctrl[`RSC_CTRL_SPD_BIT] = c_q.an_sync[1];
                c_d.adv = c_q.an_sync[1] ? `RSC_ADV_HI : `RSC_ADV_LO;
                c_d.st = rsc_pkg::RSC_RUN;
            end
            rsc_pkg::RSC_RUN: begin
                c_d.led_oe = 1'b1;
                c_d.led = ~c_q.tx_sync[1];
            end
            default: begin
                c_d.st = rsc_pkg::RSC_WAIT;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            c_q <= '{st: rsc_pkg::RSC_WAIT, wait_cnt: 2'h0, an_sync: 2'h0,
                ad_sync: 2'h0, tx_sync: 2'h0, mgmt_addr: `RSC_ADDR_LO,
                ctrl: `RSC_CTRL_BASE, adv: `RSC_ADV_LO, waitreq: 1'b1,
                rdata: 32'h0, led: 1'b1, led_oe: 1'b0};
        end else begin
            c_q <= c_d;
        end
    end

    // ****************************************
    // link domain
    // ****************************************
    always_comb begin
        l_d = l_q;
        l_d.cap_sync = {l_q.cap_sync[0], c_q.led_oe};
        l_d.loop_sync = {l_q.loop_sync[0], c_q.ctrl[`RSC_CTRL_LOOP_BIT]};
        l_d.crs_oe = l_q.cap_sync[1];
        l_d.crs_dv = 1'b0;
        l_d.rxd = 2'h0;
        if (l_q.cap_sync[1]) begin
            // loopback trades the line path for the mac transmit dibits
            l_d.crs_dv = l_q.loop_sync[1] ? txen : rx_valid;
            if (l_d.crs_dv) begin
                l_d.rxd = l_q.loop_sync[1] ? txd : rx_dibit;
            end
        end
        l_d.txv = txen;
        l_d.txd = txen ? txd : 2'h0;
    end

    always_ff @(posedge rmii_ref_clk or negedge rstn) begin
        if (!rstn) begin
            l_q <= '{cap_sync: 2'h0, loop_sync: 2'h0, crs_dv: 1'b0, rxd: 2'h0,
                crs_oe: 1'b0, txv: 1'b0, txd: 2'h0};
        end else begin
            l_q <= l_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign avs_readdata = c_q.rdata;
    assign avs_waitrequest = c_q.waitreq;
    assign led = c_q.led;
    assign led_oe = c_q.led_oe;
    assign mgmt_addr = c_q.mgmt_addr;
    assign an_enable = c_q.ctrl[`RSC_CTRL_AN_BIT];
    assign speed_100 = c_q.ctrl[`RSC_CTRL_SPD_BIT];
    assign crs_dv = l_q.crs_dv;
    assign crs_dv_oe = l_q.crs_oe;
    assign rxd = l_q.rxd;
    assign tx_valid = l_q.txv;
    assign tx_dibit = l_q.txd;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence seq_capture;
        (c_q.st == rsc_pkg::RSC_WAIT) ##1 (c_q.st == rsc_pkg::RSC_CAP);
    endsequence

    pin_input_a: assert property (c_q.st != rsc_pkg::RSC_RUN |-> !led_oe)
        else $error("strap pin driven before capture");
    pin_output_a: assert property (seq_capture |=> ##1 led_oe)
        else $error("strap pin not turned to output");
    addr_high_a: assert property (
        c_q.st == rsc_pkg::RSC_CAP && c_q.ad_sync[1] |=> mgmt_addr == 5'h03)
        else $error("address strap high not captured");
    addr_low_a: assert property (
        c_q.st == rsc_pkg::RSC_CAP && !c_q.ad_sync[1] |=> mgmt_addr == 5'h00)
        else $error("address strap low not captured");
    addr_upper_a: assert property (mgmt_addr[4:2] == 3'b000)
        else $error("upper address bits not zero");
    speed_load_a: assert property (c_q.st == rsc_pkg::RSC_CAP |=>
        an_enable == $past(c_q.an_sync[1]) && speed_100 == $past(c_q.an_sync[1])
        && c_q.adv == ($past(c_q.an_sync[1]) ? 16'h01e1 : 16'h0061))
        else $error("speed strap not loaded");
    strap_hold_a: assert property (
        c_q.st == rsc_pkg::RSC_RUN && !(avs_write && !avs_waitrequest)
        |=> $stable(mgmt_addr) && $stable(c_q.ctrl) && $stable(c_q.adv))
        else $error("strap values changed without software write");
    crs_order_a: assert property (@(posedge rmii_ref_clk) disable iff (!rstn)
        $rose(crs_dv_oe) |-> $past(l_q.cap_sync[1], 1) && c_q.st == rsc_pkg::RSC_RUN)
        else $error("crs_dv driven before strap capture");
    rx_pass_a: assert property (@(posedge rmii_ref_clk) disable iff (!rstn)
        rx_valid && l_q.cap_sync[1] && !l_q.loop_sync[1]
        |=> crs_dv && rxd == $past(rx_dibit))
        else $error("receive dibit not delivered");
    tx_take_a: assert property (@(posedge rmii_ref_clk) disable iff (!rstn)
        txen ##1 !txen |-> tx_valid ##1 !tx_valid)
        else $error("transmit dibit count wrong");
    tx_data_a: assert property (@(posedge rmii_ref_clk) disable iff (!rstn)
        txen |=> tx_valid && tx_dibit == $past(txd))
        else $error("transmit dibit not taken");

    tx_zero_a: assert property (@(posedge rmii_ref_clk) disable iff (!rstn)
        !tx_valid |-> tx_dibit == 2'h0)
        else $error("transmit dibit not cleared when idle");

    // ****************************************
    // link receive checks
    // ****************************************
    // idle pins must read zero so the mac never sees a stale dibit
    rx_zero_a: assert property (@(posedge rmii_ref_clk) disable iff (!rstn)
        !crs_dv |-> rxd == 2'h0)
        else $error("receive dibit not cleared when idle");

    rx_gap_a: assert property (@(posedge rmii_ref_clk) disable iff (!rstn)
        !rx_valid && !l_q.loop_sync[1] |=> !crs_dv)
        else $error("carrier sense without receive data");

    rx_idle_a: assert property (@(posedge rmii_ref_clk) disable iff (!rstn)
        !l_q.cap_sync[1] |=> !crs_dv && rxd == 2'h0)
        else $error("receive path active before capture");

    loop_pass_a: assert property (@(posedge rmii_ref_clk) disable iff (!rstn)
        txen && l_q.cap_sync[1] && l_q.loop_sync[1]
        |=> crs_dv && rxd == $past(txd))
        else $error("loopback dibit not delivered");

    // ****************************************
    // capture sequencing checks
    // ****************************************
    wait_count_a: assert property (
        c_q.st == rsc_pkg::RSC_WAIT |-> c_q.wait_cnt != 2'h3)
        else $error("settle counter overran");

    capture_step_a: assert property (
        c_q.st == rsc_pkg::RSC_WAIT && c_q.wait_cnt == 2'h2 |=> c_q.st == rsc_pkg::RSC_CAP)
        else $error("capture not started after settle");

    // the straps are taken once per reset release, never again
    run_stays_a: assert property (c_q.st == rsc_pkg::RSC_RUN |=> c_q.st == rsc_pkg::RSC_RUN)
        else $error("strap capture repeated");

    // ****************************************
    // register bus checks
    // ****************************************
    sequence seq_bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence seq_bus_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    bus_answer_a: assert property (seq_bus_req |=> seq_bus_answer)
        else $error("bus answer timing wrong");

    read_hold_a: assert property (!avs_waitrequest |=> $stable(avs_readdata))
        else $error("read data changed after answer");

    write_land_a: assert property (
        avs_write && !avs_waitrequest && avs_address == `RSC_REG_CTRL
        && c_q.st == rsc_pkg::RSC_RUN |=> c_q.ctrl == $past(avs_writedata[15:0]))
        else $error("control write did not land");

    adv_land_a: assert property (
        avs_write && !avs_waitrequest && avs_address == `RSC_REG_ADV
        && c_q.st == rsc_pkg::RSC_RUN |=> c_q.adv == $past(avs_writedata[15:0]))
        else $error("advertisement write did not land");

    strap_ro_a: assert property (
        avs_write && !avs_waitrequest && avs_address == `RSC_REG_STRAP
        |=> $stable(c_q.ctrl) && $stable(c_q.adv) && $stable(mgmt_addr))
        else $error("status register write changed state");

endmodule : rsc_top

// ---- verif/rsc_mac_model.sv ----
`timescale 1ns/1ps
// ****************************************
// mac side of the rmii transmit path
// ****************************************
module rsc_mac_model (
    input wire logic ref_clk,
    input wire logic en,
    input wire logic [2:0] rnd,
    output logic txen,
    output logic [1:0] txd
);
    initial begin
        txen = 1'h0;
        txd = 2'h0;
    end
    always @(posedge ref_clk) begin
        txen <= en & rnd[2];
        // idle data inverts so a stale dibit never passes as valid
        txd <= (en & rnd[2]) ? rnd[1:0] : ~txd;
    end
endmodule : rsc_mac_model

// ---- verif/test_rsc_top.sv ----
`timescale 1ns/1ps
`include "rsc_defs.svh"
module test_rsc_top;
    logic mclk = 1'h0, rmii_ref_clk = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic an_pull = 1'h1, ad_pull = 1'h0, rx_valid = 1'h0, act = 1'h0, lb = 1'h0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, r = 32'hcb5a, avs_readdata;
    logic [1:0] rx_dibit = 2'h0, rxd, txd, tx_dibit;
    logic avs_waitrequest, crs_dv, crs_dv_oe, led, led_oe, txen, tx_valid, an_enable, speed_100;
    logic [4:0] mgmt_addr;
    wire logic mgmt_address_strap, autoneg_speed_strap;
    int num_errors = 0, compares = 0;
    logic [31:0] rq[$];
    logic [1:0] lq[$], tq[$];
    // ****************************************
    // clocks, pins and instances
    // ****************************************
    always #10 mclk = ~mclk;
    always #7.5 rmii_ref_clk = ~rmii_ref_clk;
    // strap pins fall back to the board pull while the device does not drive them
    assign mgmt_address_strap = crs_dv_oe ? crs_dv : ad_pull;
    assign autoneg_speed_strap = led_oe ? led : an_pull;
    rsc_top DUT (.*);
    rsc_mac_model MAC (.ref_clk(rmii_ref_clk), .en(act), .rnd(r[2:0]), .txen(txen), .txd(txd));
    // ****************************************
    // checking helpers
    // ****************************************
    task automatic conclude;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic take(ref logic [1:0] q[$], input logic [1:0] got);
        if (q.size() == 0) chk(got, 32'hffff_ffff);
        else chk(got, q.pop_front());
    endtask : take
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    // link side: the watcher compares before the driver notes
    always @(posedge rmii_ref_clk) begin
        if (crs_dv === 1'h1) take(lq, rxd);
        else chk(rxd, 0);
        if (tx_valid === 1'h1) take(tq, tx_dibit);
        else chk(tx_dibit, 0);
        if (txen === 1'h1) tq.push_back(txd);
        r <= xs(r);
        rx_valid <= act & r[3];
        rx_dibit <= r[5:4];
        if (lb && txen === 1'h1) lq.push_back(txd);
        if (!lb && (act & r[3])) lq.push_back(r[5:4]);
    end
    always @(posedge mclk) begin
        if (avs_read === 1'h1 && avs_waitrequest === 1'h0) chk(avs_readdata, rq.pop_front());
    end
    // ****************************************
    // bus, reset and traffic tasks
    // ****************************************
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'h0) break;
        end
        if (n == 20) begin
            num_errors++;
            conclude();
        end
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(a, 1'h0, 32'h0);
    endtask : rd
    task automatic boot(input logic an, input logic ad);
        int n;
        @(posedge mclk);
        an_pull <= an;
        ad_pull <= ad;
        rstn <= 1'h0;
        repeat (12) @(posedge mclk);
        chk({led_oe, crs_dv_oe}, 0);
        rstn <= 1'h1;
        for (n = 0; n < 60 && crs_dv_oe !== 1'h1; n++) @(negedge mclk);
        if (n == 60) begin
            num_errors++;
            conclude();
        end
        chk(led_oe, 1);
        chk(mgmt_addr, ad ? `RSC_ADDR_HI : `RSC_ADDR_LO);
        chk({an_enable, speed_100}, {an, an});
        rd(`RSC_REG_ADV, an ? `RSC_ADV_HI : `RSC_ADV_LO);
        rd(`RSC_REG_CTRL, `RSC_CTRL_BASE | {an, an, 12'h000});
        rd(`RSC_REG_STRAP, 32'h0000_0100 | (ad ? `RSC_ADDR_HI : `RSC_ADDR_LO));
        chk(led, 1);
    endtask : boot
    task automatic traffic(input int cyc);
        act <= 1'h1;
        repeat (cyc) @(posedge mclk);
        act <= 1'h0;
        repeat (10) @(posedge mclk);
        chk(lq.size() + tq.size(), 0);
    endtask : traffic
    initial begin
        boot(1'h1, 1'h1);
        ad_pull <= 1'h0;
        an_pull <= 1'h0;
        traffic(300);
        chk(mgmt_addr, `RSC_ADDR_HI);
        bus(`RSC_REG_CTRL, 1'h1, 32'h0000_2100);
        rd(`RSC_REG_CTRL, 32'h0000_2100);
        rd(4'hc, 32'h0);
        repeat (3) @(negedge mclk);
        chk({an_enable, speed_100}, 2'h1);
        bus(`RSC_REG_CTRL, 1'h1, 32'h0000_4100);
        repeat (5) @(posedge mclk);
        lb <= 1'h1;
        traffic(100);
        lb <= 1'h0;
        boot(1'h0, 1'h0);
        traffic(200);
        conclude();
    end
endmodule : test_rsc_top
